//--- core/pcc_top.sv
// palette and cursor color access registers with component sequencing
// What this block does
// - holds 8-bit palette write index
// - red green blue writes, commit on blue
// - write index steps after blue write
// - step when blue commits the entry to the table
// - read index load fetches entry, three reads
// - read index steps on holding load
// - color port uses write or read index
// - cursor red green blue writes, commit on blue
// - cursor write index steps on blue
// - cursor read index fetches, three reads
// - cursor read index steps on fetch
// - mask palette index in indexed modes
// - registers decoded inside second memory window
// - status shows next color component
// - status shows last operation direction
// - six-bit mode zeroes two palette data LSBs
`timescale 1ns/1ns
`default_nettype none
module pcc_top
  import pcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_win_hit,
  input  wire logic [15:0] acc_addr,
  input  wire logic [31:0] acc_wdata,
  output logic             acc_ack,
  output logic      [31:0] acc_rdata,
  input  wire logic        host_color_resolution_select,
  input  wire logic [7:0]  pix_index,
  input  wire logic        pix_indexed,
  output logic      [23:0] pix_color,
  input  wire logic [7:0]  cursor_disp_index,
  output logic      [23:0] cursor_color
);

  logic       take;
  logic       wr;
  logic       rd;
  logic       hit_pwi;
  logic       hit_pcp;
  logic       hit_pmask;
  logic       hit_pri;
  logic       hit_cwi;
  logic       hit_ccp;
  logic       hit_cri;
  logic       hit_stat;
  logic       idx_load;
  logic       color_acc;
  logic [7:0] res_mask;
  logic [7:0] pal_wbyte;
  logic [7:0] palette_index_mask;
  logic       previous_op_direction;
  pcc_comp_t  color_component_pointer;
  pcc_comp_t  next_comp;
  logic [7:0] pal_wr_idx;
  logic [7:0] pal_rd_idx;
  logic [7:0] pal_rd_byte;
  logic [7:0] cur_wr_idx;
  logic [7:0] cur_rd_idx;
  logic [7:0] cur_rd_byte;
  logic [7:0] pal_disp_index;

  // only accesses that fall in the second memory window are ours
  assign take = acc_valid && acc_win_hit;
  assign wr   = take && acc_write;
  assign rd   = take && !acc_write;

  // word address decode, byte lanes below bit 2 ignored
  assign hit_pwi   = acc_addr[15:2] == OFF_PAL_WR_IDX[15:2];
  assign hit_pcp   = acc_addr[15:2] == OFF_PAL_PORT[15:2];
  assign hit_pmask = acc_addr[15:2] == OFF_PAL_MASK[15:2];
  assign hit_pri   = acc_addr[15:2] == OFF_PAL_RD_IDX[15:2];
  assign hit_cwi   = acc_addr[15:2] == OFF_CUR_WR_IDX[15:2];
  assign hit_ccp   = acc_addr[15:2] == OFF_CUR_PORT[15:2];
  assign hit_cri   = acc_addr[15:2] == OFF_CUR_RD_IDX[15:2];
  assign hit_stat  = acc_addr[15:2] == OFF_STATUS[15:2];

  // index loads and color port accesses drive the component pointer
  assign idx_load  = wr && (hit_pwi || hit_pri || hit_cwi || hit_cri);
  assign color_acc = take && (hit_pcp || hit_ccp);

  // host palette data resolution; only the low byte is used, upper bits ignored
  assign res_mask  = host_color_resolution_select ? RES8_MASK : RES6_MASK;
  assign pal_wbyte = acc_wdata[7:0] & res_mask;

  // next component: index write restarts at red, port access steps round
  always_comb begin
    next_comp = color_component_pointer;
    if (idx_load) begin
      next_comp = COMP_RED;
    end else if (color_acc) begin
      case (color_component_pointer)
        COMP_RED:   next_comp = COMP_GREEN;
        COMP_GREEN: next_comp = COMP_BLUE;
        COMP_BLUE:  next_comp = COMP_RED;
        default:    next_comp = COMP_RED;
      endcase
    end
  end

  // component pointer register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      color_component_pointer <= COMP_RED;
    end else begin
      color_component_pointer <= next_comp;
    end
  end

  // last operation direction, set by the kind of index written
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      previous_op_direction <= DIR_WRITE;
    end else if (wr && (hit_pwi || hit_cwi)) begin
      previous_op_direction <= DIR_WRITE;
    end else if (wr && (hit_pri || hit_cri)) begin
      previous_op_direction <= DIR_READ;
    end
  end

  // pixel mask register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      palette_index_mask <= MASK_RST;
    end else if (wr && hit_pmask) begin
      palette_index_mask <= acc_wdata[7:0];
    end
  end

  // mask applies only while an indexed mode is on the screen
  assign pal_disp_index = pix_indexed ? (pix_index & palette_index_mask) : pix_index;

  // palette table
  pcc_color_channel #(
    .AW (IDX_W)
  ) u_palette (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .ld_wr_idx  (wr && hit_pwi),
    .ld_rd_idx  (wr && hit_pri),
    .idx_value  (acc_wdata[7:0]),
    .port_wr    (wr && hit_pcp),
    .port_rd    (rd && hit_pcp),
    .comp       (color_component_pointer),
    .wr_byte    (pal_wbyte),
    .wr_idx     (pal_wr_idx),
    .rd_idx     (pal_rd_idx),
    .rd_byte    (pal_rd_byte),
    .disp_index (pal_disp_index),
    .disp_color (pix_color)
  );

  // cursor color table
  pcc_color_channel #(
    .AW (IDX_W)
  ) u_cursor (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .ld_wr_idx  (wr && hit_cwi),
    .ld_rd_idx  (wr && hit_cri),
    .idx_value  (acc_wdata[7:0]),
    .port_wr    (wr && hit_ccp),
    .port_rd    (rd && hit_ccp),
    .comp       (color_component_pointer),
    .wr_byte    (acc_wdata[7:0]),
    .wr_idx     (cur_wr_idx),
    .rd_idx     (cur_rd_idx),
    .rd_byte    (cur_rd_byte),
    .disp_index (cursor_disp_index),
    .disp_color (cursor_color)
  );

  // acknowledge one cycle after each window access
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ack <= 1'b0;
    end else begin
      acc_ack <= take;
    end
  end

  // read data: low byte holds the field, upper bits read zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_rdata <= RDATA_RST;
    end else if (rd) begin
      acc_rdata <= RDATA_RST;
      if (hit_pwi) begin
        acc_rdata[7:0] <= pal_wr_idx;
      end else if (hit_pcp) begin
        acc_rdata[7:0] <= pal_rd_byte & res_mask;
      end else if (hit_pmask) begin
        acc_rdata[7:0] <= palette_index_mask;
      end else if (hit_pri) begin
        acc_rdata[7:0] <= pal_rd_idx;
      end else if (hit_cwi) begin
        acc_rdata[7:0] <= cur_wr_idx;
      end else if (hit_ccp) begin
        acc_rdata[7:0] <= cur_rd_byte;
      end else if (hit_cri) begin
        acc_rdata[7:0] <= cur_rd_idx;
      end else if (hit_stat) begin
        acc_rdata[ST_COMP_MSB:ST_COMP_LSB] <= color_component_pointer;
        acc_rdata[ST_DIR_BIT]              <= previous_op_direction;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // index load followed by a port access on the next cycle
  sequence s_idx_then_port;
    idx_load ##1 (color_acc && !idx_load);
  endsequence

  sequence s_pal_triplet;
    (wr && hit_pwi) ##1 (wr && hit_pcp)[*3];
  endsequence

  // cursor index load followed by a full triplet on consecutive cycles
  sequence s_cur_triplet;
    (wr && hit_cwi) ##1 (wr && hit_ccp)[*3];
  endsequence

  // component pointer, direction, triplet, ack, read data, mask and cursor read checks
  a_ptr_to_red: assert property (idx_load |=> color_component_pointer == COMP_RED)
    else $error("index write did not reset component to red");
  a_ptr_first_step: assert property (s_idx_then_port |=> color_component_pointer == COMP_GREEN)
    else $error("component did not step to green");
  a_ptr_wrap: assert property (color_acc && !idx_load && color_component_pointer == COMP_BLUE
    |=> color_component_pointer == COMP_RED)
    else $error("component did not wrap after blue");
  a_ptr_legal: assert property (color_component_pointer != 2'h3)
    else $error("reserved component code reached");
  a_dir_write: assert property (wr && (hit_pwi || hit_cwi) |=> previous_op_direction == DIR_WRITE)
    else $error("direction not write after write index");
  a_dir_read: assert property (wr && (hit_pri || hit_cri) |=> previous_op_direction == DIR_READ)
    else $error("direction not read after read index");
  a_pal_triplet: assert property (s_pal_triplet |=> pal_wr_idx == $past(acc_wdata[7:0], 4) + 1'b1)
    else $error("palette write index not advanced after triplet");
  a_ack_timing: assert property (take |=> acc_ack ##1 (!acc_ack || $past(take)))
    else $error("ack not one cycle after access");
  a_no_stray_ack: assert property (!take |=> !acc_ack)
    else $error("ack without window access");
  a_six_bit_read: assert property (rd && hit_pcp && !host_color_resolution_select
    |=> acc_rdata[1:0] == 2'h0)
    else $error("six-bit read returned nonzero LSBs");
  a_mask_index: assert property (pix_indexed |-> (pal_disp_index & ~palette_index_mask) == 8'h00)
    else $error("masked index bits leaked to display");
  a_cur_rd_step: assert property (rd && hit_ccp && !idx_load && color_component_pointer == COMP_BLUE
    |=> cur_rd_idx == $past(cur_rd_idx) + 1'b1)
    else $error("cursor read index not stepped on fetch");

  // index loading and stepping on the table side
  a_cur_triplet: assert property (s_cur_triplet
    |=> cur_wr_idx == $past(acc_wdata[7:0], 4) + 1'b1)
    else $error("cursor write index not advanced after triplet");
  a_pal_rd_step: assert property (rd && hit_pcp
    && color_component_pointer == COMP_BLUE |=> pal_rd_idx == $past(pal_rd_idx) + 1'b1)
    else $error("palette read index not stepped on fetch");
  a_pal_wr_load: assert property (wr && hit_pwi
    |=> pal_wr_idx == $past(acc_wdata[7:0]))
    else $error("palette write index not loaded");
  a_cur_rd_load: assert property (wr && hit_cri
    |=> cur_rd_idx == $past(acc_wdata[7:0]) + 1'b1)
    else $error("cursor read index not loaded plus one");

  // register bus answers
  a_status_read: assert property (rd && hit_stat
    |=> acc_rdata == {29'h0, $past(previous_op_direction), $past(color_component_pointer)})
    else $error("status read does not match pointer and direction");
  a_unmapped_zero: assert property (rd
    && !(hit_pwi || hit_pcp || hit_pmask || hit_pri || hit_cwi || hit_ccp || hit_cri || hit_stat)
    |=> acc_rdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");
  a_miss_no_effect: assert property (acc_valid && !acc_win_hit
    |=> !acc_ack && $stable(color_component_pointer) && $stable(previous_op_direction))
    else $error("access outside the window had an effect");
  a_mask_write: assert property (wr && hit_pmask
    |=> palette_index_mask == $past(acc_wdata[7:0]))
    else $error("pixel mask not loaded from write data");

  // state that must hold still between its events
  a_dir_hold: assert property (!idx_load |=> $stable(previous_op_direction))
    else $error("direction changed without an index write");
  a_ptr_idle: assert property (!idx_load && !color_acc
    |=> $stable(color_component_pointer))
    else $error("component pointer moved without an access");

endmodule // pcc_top
`default_nettype wire

//--- core/pcc_pkg.sv
// shared constants and types for the palette and cursor color access block
package pcc_pkg;

  // register byte addresses inside the second memory window
  localparam logic [15:0] OFF_PAL_WR_IDX  = 16'h1000;
  localparam logic [15:0] OFF_PAL_PORT    = 16'h1004;
  localparam logic [15:0] OFF_PAL_MASK    = 16'h1008;
  localparam logic [15:0] OFF_PAL_RD_IDX  = 16'h100C;
  localparam logic [15:0] OFF_CUR_WR_IDX  = 16'h1010;
  localparam logic [15:0] OFF_CUR_PORT    = 16'h1014;
  localparam logic [15:0] OFF_CUR_RD_IDX  = 16'h101C;
  localparam logic [15:0] OFF_STATUS      = 16'h1028;

  // field widths
  localparam int IDX_W  = 8;
  localparam int BYTE_W = 8;
  localparam int RGB_W  = 24;

  // status field positions
  localparam int ST_COMP_LSB = 0;
  localparam int ST_COMP_MSB = 1;
  localparam int ST_DIR_BIT  = 2;

  // reset values (hardware leaves these undefined; zero and all-pass chosen)
  localparam logic [7:0]  IDX_RST   = 8'h00;
  localparam logic [7:0]  MASK_RST  = 8'hFF;
  localparam logic [23:0] RGB_RST   = 24'h000000;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  // host data masks for 6-bit and 8-bit resolution
  localparam logic [7:0] RES6_MASK = 8'hFC;
  localparam logic [7:0] RES8_MASK = 8'hFF;

  // direction of the last index load
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ  = 1'b1;

  // color component pointer, encoded as the status field shows it
  typedef enum logic [1:0] {
    COMP_RED   = 2'h0,
    COMP_GREEN = 2'h1,
    COMP_BLUE  = 2'h2
  } pcc_comp_t;

endpackage

//--- core/pcc_color_channel.sv
// one color table with write and read indices, holding registers and display port
`timescale 1ns/1ns
`default_nettype none
module pcc_color_channel
  import pcc_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  input  wire logic            ld_wr_idx,
  input  wire logic            ld_rd_idx,
  input  wire logic [AW-1:0]   idx_value,
  input  wire logic            port_wr,
  input  wire logic            port_rd,
  input  wire pcc_comp_t       comp,
  input  wire logic [7:0]      wr_byte,
  output logic      [AW-1:0]   wr_idx,
  output logic      [AW-1:0]   rd_idx,
  output logic      [7:0]      rd_byte,
  input  wire logic [AW-1:0]   disp_index,
  output logic      [23:0]     disp_color
);

  logic [7:0]    hold_r;
  logic [7:0]    hold_g;
  logic [23:0]   rd_hold;
  logic [23:0]   mem [0:(1<<AW)-1];
  logic          blue_wr;
  logic          blue_rd;
  logic [AW-1:0] fetch_addr;

  // blue strobes close a triplet
  assign blue_wr    = port_wr && (comp == COMP_BLUE);
  assign blue_rd    = port_rd && (comp == COMP_BLUE);
  assign fetch_addr = ld_rd_idx ? idx_value : rd_idx;

  // write index: load, then step as blue commits the entry to the table
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_idx <= AW'(IDX_RST);
    end else if (ld_wr_idx) begin
      wr_idx <= idx_value;
    end else if (blue_wr) begin
      wr_idx <= wr_idx + 1'b1;
    end
  end

  // red and green wait in the holding register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= 8'h00;
      hold_g <= 8'h00;
    end else if (port_wr && comp == COMP_RED) begin
      hold_r <= wr_byte;
    end else if (port_wr && comp == COMP_GREEN) begin
      hold_g <= wr_byte;
    end
  end

  // table commit only with the blue byte
  always_ff @(posedge ref_clk) begin
    if (blue_wr) begin
      mem[wr_idx] <= {hold_r, hold_g, wr_byte};
    end
  end

  // read side: fetch on index load and after each blue read, stepping the index
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_idx  <= AW'(IDX_RST);
      rd_hold <= RGB_RST;
    end else if (ld_rd_idx || blue_rd) begin
      rd_hold <= mem[fetch_addr];
      rd_idx  <= fetch_addr + 1'b1;
    end
  end

  // component selected from the read holding register
  always_comb begin
    case (comp)
      COMP_RED:   rd_byte = rd_hold[23:16];
      COMP_GREEN: rd_byte = rd_hold[15:8];
      COMP_BLUE:  rd_byte = rd_hold[7:0];
      default:    rd_byte = 8'h00;
    endcase
  end

  // display lookup
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_color <= RGB_RST;
    end else begin
      disp_color <= mem[disp_index];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_wr_idx_step: assert property (blue_wr && !ld_wr_idx |=> wr_idx == $past(wr_idx) + 1'b1)
    else $error("write index did not step after blue write");
  a_rd_idx_load: assert property (ld_rd_idx |=> rd_idx == $past(idx_value) + 1'b1)
    else $error("read index not loaded plus one");
  a_wr_idx_hold: assert property (!ld_wr_idx && !blue_wr |=> $stable(wr_idx))
    else $error("write index moved without blue write");

endmodule // pcc_color_channel
`default_nettype wire

//--- dv/pcc_host_model.sv
// host bus master model issuing single accesses, in or outside the color unit window, and four-access bursts into the window
`timescale 1ns/1ns
`default_nettype none
module pcc_host_model (
  input  wire logic        ref_clk,
  output logic             acc_valid,
  output logic             acc_write,
  output logic             acc_win_hit,
  output logic      [15:0] acc_addr,
  output logic      [31:0] acc_wdata,
  input  wire logic        acc_ack,
  input  wire logic [31:0] acc_rdata
);
  // idle bus from time zero
  initial begin
    acc_valid   = 1'b0;
    acc_write   = 1'b0;
    acc_win_hit = 1'b0;
    acc_addr    = 16'h0000;
    acc_wdata   = 32'h00000000;
  end

  // one access: one-cycle request, answer taken in the following cycle
  task automatic xfer(input logic wr, input logic hit, input logic [15:0] a,
                      input logic [7:0] d, output logic ok, output logic [31:0] q);
    @(negedge ref_clk);
    acc_valid   = 1'b1;
    acc_write   = wr;
    acc_win_hit = hit;
    acc_addr    = a;
    acc_wdata   = {24'h000000, d};
    @(negedge ref_clk);
    ok          = acc_ack;
    q           = acc_rdata;
    acc_valid   = 1'b0;
    acc_win_hit = 1'b0;
    acc_addr    = ~a; // released lines must not look like a held value
    acc_wdata   = ~acc_wdata;
  endtask

  // index write then three port writes on consecutive cycles, request held high throughout
  task automatic burst4(input logic [15:0] idx_a, input logic [15:0] port_a,
                        input logic [31:0] d, output logic [3:0] ok);
    @(negedge ref_clk);
    acc_valid   = 1'b1;
    acc_write   = 1'b1;
    acc_win_hit = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      acc_addr  = (i == 3) ? idx_a : port_a;
      acc_wdata = {24'h000000, d[8*i +: 8]};
      @(negedge ref_clk);
      ok[i]     = acc_ack;
    end
    acc_valid   = 1'b0;
    acc_win_hit = 1'b0;
    acc_addr    = ~acc_addr;
    acc_wdata   = ~acc_wdata;
  endtask
endmodule // pcc_host_model
`default_nettype wire

//--- dv/pcc_top_test.sv
// self-checking bench for the palette and cursor color access block
`timescale 1ns/1ns
`default_nettype none
module pcc_top_test
  import pcc_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b;
  logic        acc_valid, acc_write, acc_win_hit, acc_ack;
  logic [15:0] acc_addr;
  logic [31:0] acc_wdata, acc_rdata;
  logic        host_color_resolution_select;
  logic [7:0]  pix_index, cursor_disp_index;
  logic        pix_indexed;
  logic [23:0] pix_color, cursor_color;
  int          n_tests = 0;
  int          n_mismatch = 0;
  int          cycles = 0;

  pcc_top pcc_top_inst (
    .ref_clk, .rst_b, .acc_valid, .acc_write, .acc_win_hit, .acc_addr,
    .acc_wdata, .acc_ack, .acc_rdata, .host_color_resolution_select,
    .pix_index, .pix_indexed, .pix_color, .cursor_disp_index, .cursor_color
  );

  pcc_host_model pcc_host_model_inst (
    .ref_clk, .acc_valid, .acc_write, .acc_win_hit, .acc_addr, .acc_wdata,
    .acc_ack, .acc_rdata
  );

  // clock and hang guard
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic        ok;
    logic [31:0] q;
    pcc_host_model_inst.xfer(1'b1, 1'b1, a, d, ok, q);
    chk("write ack", {31'h0, ok}, 32'h1);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
    logic        ok;
    logic [31:0] q;
    pcc_host_model_inst.xfer(1'b0, 1'b1, a, 8'h00, ok, q);
    chk("read ack", {31'h0, ok}, 32'h1);
    chk(nm, q, exp);
  endtask

  // display lookup shows up one cycle after the index
  task automatic pix(input logic [7:0] i, input logic ix, input logic [23:0] exp);
    @(negedge ref_clk);
    pix_index = i;
    pix_indexed = ix;
    @(negedge ref_clk);
    chk("pix color", {8'h00, pix_color}, {8'h00, exp});
  endtask

  task automatic t_reset();
    rd(OFF_STATUS, 32'h0, "status");
    rd(OFF_PAL_WR_IDX, 32'h0, "pal wr idx");
    rd(OFF_PAL_MASK, 32'hFF, "mask");
    $display("done reset");
  endtask

  task automatic t_pal_write();
    wr(OFF_PAL_WR_IDX, 8'hFE);
    wr(OFF_PAL_PORT, 8'h11);
    wr(OFF_PAL_PORT, 8'h22);
    rd(OFF_STATUS, 32'h2, "status blue");
    wr(OFF_PAL_PORT, 8'h33);
    rd(OFF_PAL_WR_IDX, 32'hFF, "wr idx step");
    rd(OFF_STATUS, 32'h0, "status red");
    wr(OFF_PAL_PORT, 8'h44);
    wr(OFF_PAL_PORT, 8'h55);
    wr(OFF_PAL_PORT, 8'h66);
    rd(OFF_PAL_WR_IDX, 32'h0, "wr idx wrap");
    pix(8'hFE, 1'b0, 24'h112233);
    pix(8'hFF, 1'b0, 24'h445566);
    $display("done palette write");
  endtask

  task automatic t_pal_read();
    wr(OFF_PAL_RD_IDX, 8'hFE);
    rd(OFF_STATUS, 32'h4, "status read");
    rd(OFF_PAL_RD_IDX, 32'hFF, "rd idx fetch");
    rd(OFF_PAL_PORT, 32'h11, "pal red");
    rd(OFF_PAL_PORT, 32'h22, "pal green");
    rd(OFF_PAL_PORT, 32'h33, "pal blue");
    rd(OFF_PAL_RD_IDX, 32'h0, "rd idx next");
    rd(OFF_PAL_PORT, 32'h44, "pal next red");
    $display("done palette read");
  endtask

  task automatic t_cursor();
    logic [7:0] cb [6] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6};
    host_color_resolution_select = 1'b0;
    wr(OFF_CUR_WR_IDX, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CUR_PORT, cb[i]);
    end
    rd(OFF_CUR_WR_IDX, 32'h5, "cur wr idx");
    @(negedge ref_clk);
    cursor_disp_index = 8'h04;
    @(negedge ref_clk);
    chk("cursor color", {8'h00, cursor_color}, 32'h00D4E5F6);
    wr(OFF_CUR_RD_IDX, 8'h03);
    rd(OFF_CUR_RD_IDX, 32'h4, "cur rd idx");
    for (int i = 0; i < 4; i++) begin
      rd(OFF_CUR_PORT, {24'h000000, cb[i]}, "cursor byte");
    end
    rd(OFF_CUR_RD_IDX, 32'h5, "cur rd idx next");
    $display("done cursor");
  endtask

  task automatic t_mask_res();
    wr(OFF_PAL_WR_IDX, 8'h0E);
    wr(OFF_PAL_PORT, 8'h37);
    wr(OFF_PAL_PORT, 8'h5A);
    wr(OFF_PAL_PORT, 8'hFF);
    wr(OFF_PAL_RD_IDX, 8'h0E);
    rd(OFF_PAL_PORT, 32'h34, "six bit red");
    rd(OFF_PAL_PORT, 32'h58, "six bit green");
    rd(OFF_PAL_PORT, 32'hFC, "six bit blue");
    wr(OFF_PAL_MASK, 8'hFE);
    rd(OFF_PAL_MASK, 32'hFE, "mask");
    pix(8'hFF, 1'b1, 24'h112233);
    pix(8'hFF, 1'b0, 24'h445566);
    $display("done mask and resolution");
  endtask

  task automatic t_misc();
    logic        ok;
    logic [31:0] q;
    wr(OFF_PAL_PORT, 8'h01);
    wr(OFF_PAL_PORT, 8'h02);
    rd(OFF_STATUS, 32'h6, "status partial");
    wr(OFF_CUR_RD_IDX, 8'h00);
    rd(OFF_STATUS, 32'h4, "status rewind");
    pcc_host_model_inst.xfer(1'b1, 1'b0, OFF_PAL_WR_IDX, 8'h55, ok, q);
    chk("miss ack", {31'h0, ok}, 32'h0);
    rd(OFF_PAL_WR_IDX, 32'hF, "idx after miss");
    rd(16'h1018, 32'h0, "unmapped");
    wr(OFF_STATUS, 8'h03);
    rd(OFF_STATUS, 32'h4, "status ro");
    $display("done misc");
  endtask

  // index write and a full triplet on consecutive cycles, both tables
  task automatic t_burst();
    logic [3:0] ok;
    pcc_host_model_inst.burst4(OFF_PAL_WR_IDX, OFF_PAL_PORT, 32'h20123456, ok);
    chk("pal burst acks", {28'h0, ok}, 32'hF);
    rd(OFF_PAL_WR_IDX, 32'h21, "pal burst idx");
    pix(8'h20, 1'b0, 24'h123456);
    pcc_host_model_inst.burst4(OFF_CUR_WR_IDX, OFF_CUR_PORT, 32'h40ABCDEF, ok);
    chk("cur burst acks", {28'h0, ok}, 32'hF);
    rd(OFF_CUR_WR_IDX, 32'h41, "cur burst idx");
    rd(OFF_STATUS, 32'h0, "burst status");
    @(negedge ref_clk);
    cursor_disp_index = 8'h40;
    @(negedge ref_clk);
    chk("cur burst color", {8'h00, cursor_color}, 32'h00ABCDEF);
    $display("done burst");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    rst_b = 1'b0;
    host_color_resolution_select = 1'b1;
    pix_index = 8'h00;
    pix_indexed = 1'b0;
    cursor_disp_index = 8'h00;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset();
    t_pal_write();
    t_pal_read();
    t_burst();
    t_cursor();
    t_mask_res();
    t_misc();
    close_out();
  end
endmodule // pcc_top_test
`default_nettype wire
